// ===== design/serdes_pcs_consts.svh
// constants for the media pcs control and tx crc counter register bank
`ifndef SERDES_PCS_CONSTS_SVH
`define SERDES_PCS_CONSTS_SVH
`define IDX_TXCRC    8'h16
`define IDX_PCSCTL   8'h17
`define IDX_ADV      8'h19
`define TXCRC_WMASK  16'he000
`define PCSCTL_WMASK 16'h3877
`define PCSCTL_RST   16'h1010
`define ADV_RST      16'h0000
`define SEL_MEDIA    2'h0
`define SEL_MAC      2'h1
`define BIT_PREFIX   13
`define BIT_PARDET   13
`define BIT_CEXTDIS  12
`define BIT_FORCEADV 11
`define BIT_RXPOL    6
`define BIT_TXPOL    5
`define BIT_ODDINH   4
`define BIT_HLS      2
`define BIT_FFEFI    1
`define BIT_FEFIVAL  0
`define PRE_MAX      5'h08
`define CNT_MAX      8'hff
`endif

// ===== design/serdes_pcs_pkg.sv
// types shared by the media pcs control block
package serdes_pcs_pkg;
  typedef struct packed {
    logic preamble_fix;
    logic par_det_en;
    logic carrier_ext_dis;
    logic force_adv;
    logic rx_pol_inv;
    logic tx_pol_inv;
    logic odd_inhibit;
    logic force_hls;
    logic force_fefi;
    logic fefi_val;
  } pcs_ctrl_t;
  typedef struct packed {
    logic drop_pre_byte;
    logic drop_first_55;
    logic delay_one_byte;
  } egress_act_t;
endpackage

// ===== design/serdes_pcs_ctrl_tx_crc_counter.sv
// media pcs control and tx crc error counter register bank on apb
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "serdes_pcs_consts.svh"

// Notes on behaviour
// - selector 00 media, 01 mac, others reserved
// - preamble fix drops one byte above eight
// - eight bit crc error count saturates
// - counters advance only while media link up
// - read back remote fault sent to media
// - read-write bit enables parallel detection
// - carrier extension disable, resets to one
// - force bit selects stored advertised word
// - two bits invert rx and tx polarity
// - odd start drops 0x55 or delays
// - force hls sends halt line state
// - force fefi takes value bit
// - fefi value bit on or suppress
// - advertised word resets zero, gated writes
module serdes_pcs_ctrl_tx_crc_counter #(
  parameter int ADDR_W = 12                        // apb address width
) (
  input  wire logic                      pclk,              // apb clock, 20 mhz
  input  wire logic                      presetn,           // async reset, active low
  input  wire logic                      psel,              // apb select
  input  wire logic                      penable,           // apb access phase
  input  wire logic                      pwrite,            // apb direction
  input  wire logic [ADDR_W-1:0]         paddr,             // apb byte address
  input  wire logic [31:0]               pwdata,            // apb write data
  input  wire logic [3:0]                pstrb,             // apb byte strobes
  output logic      [31:0]               prdata,            // apb read data
  output logic                           pready,            // apb ready
  output logic                           pslverr,           // apb error
  input  wire logic                      media_link_up,     // media link state, async pin
  input  wire logic                      media_tx_crc_err,  // media tx crc error pulse
  input  wire logic                      mac_tx_crc_err,    // mac tx crc error pulse
  input  wire logic [1:0]                remote_fault_sent, // remote fault sent in last exchange
  input  wire logic [15:0]               auto_adv_word,     // automatically built ability word
  input  wire logic                      fefi_auto,         // automatic far-end fault request
  input  wire logic                      egress_sof,        // egress frame start pulse
  input  wire logic [4:0]                preamble_len,      // preamble bytes of this frame
  input  wire logic                      odd_start,         // frame starts on odd byte
  output serdes_pcs_pkg::pcs_ctrl_t      ctrl,              // control bits to the pcs
  output serdes_pcs_pkg::egress_act_t    egress_act,        // per-frame egress actions
  output logic      [15:0]               adv_word_tx,       // ability word sent on media
  output logic                           fefi_tx,           // far-end fault to transmit
  output logic                           hls_tx             // halt line state to transmit
);

  // the highest register index times four must fit the address
  if (ADDR_W < 7) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  // address decode, used for read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // link state synchroniser
  logic        link_meta_reg;   // first stage, read only by second
  logic        link_up_reg;     // synchronised link state
  // stored registers
  logic [15:0] txcrc_reg;       // writable bits of the counter register
  logic [15:0] pcsctl_reg;      // writable bits of the pcs control register
  logic [15:0] adv_reg;         // stored advertised ability word
  logic [7:0]  cnt_reg [2];     // 0 media, 1 mac crc error counts
  logic [31:0] prdata_reg;      // read data captured in setup

  // decode
  // a write lands only on a mapped register in the access phase
  wire         sel_txcrc  = hit(paddr, `IDX_TXCRC);
  wire         sel_pcsctl = hit(paddr, `IDX_PCSCTL);
  wire         sel_adv    = hit(paddr, `IDX_ADV);
  wire         addr_ok    = sel_txcrc | sel_pcsctl | sel_adv;
  wire         setup_ph   = psel & ~penable;
  wire         access_ph  = psel & penable;
  wire         wr_go      = access_ph & pwrite & addr_ok;
  wire  [15:0] lane_m     = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire  [1:0]  cnt_sel    = txcrc_reg[15:14];
  wire  [1:0]  ev         = {mac_tx_crc_err, media_tx_crc_err};

  // counter view follows the selector; reserved codes read zero
  wire  [7:0]  cnt_view   = (cnt_sel == `SEL_MEDIA) ? cnt_reg[0] :
                            (cnt_sel == `SEL_MAC)   ? cnt_reg[1] : 8'h00;

  // masked write values; reserved bits never stored
  wire  [15:0] wm_txcrc   = lane_m & `TXCRC_WMASK;
  wire  [15:0] wm_pcsctl  = lane_m & `PCSCTL_WMASK;
  wire  [15:0] txcrc_next  = (txcrc_reg & ~wm_txcrc) | (pwdata[15:0] & wm_txcrc);
  wire  [15:0] pcsctl_next = (pcsctl_reg & ~wm_pcsctl) | (pwdata[15:0] & wm_pcsctl);
  wire  [15:0] adv_next    = (adv_reg & ~lane_m) | (pwdata[15:0] & lane_m);

  // read words; reserved fields are zero
  wire  [15:0] txcrc_rd   = {txcrc_reg[15:13], 5'h00, cnt_view};
  wire  [15:0] pcsctl_rd  = {remote_fault_sent, pcsctl_reg[13:0]};
  wire  [15:0] rd_word    = sel_txcrc  ? txcrc_rd  :
                            sel_pcsctl ? pcsctl_rd :
                            sel_adv    ? adv_reg   : 16'h0000;

  // control bits to the pcs, straight from register flops
  assign ctrl.preamble_fix    = txcrc_reg[`BIT_PREFIX];
  assign ctrl.par_det_en      = pcsctl_reg[`BIT_PARDET];
  assign ctrl.carrier_ext_dis = pcsctl_reg[`BIT_CEXTDIS];
  assign ctrl.force_adv       = pcsctl_reg[`BIT_FORCEADV];
  assign ctrl.rx_pol_inv      = pcsctl_reg[`BIT_RXPOL];
  assign ctrl.tx_pol_inv      = pcsctl_reg[`BIT_TXPOL];
  assign ctrl.odd_inhibit     = pcsctl_reg[`BIT_ODDINH];
  assign ctrl.force_hls       = pcsctl_reg[`BIT_HLS];
  assign ctrl.force_fefi      = pcsctl_reg[`BIT_FFEFI];
  assign ctrl.fefi_val        = pcsctl_reg[`BIT_FEFIVAL];

  // zero wait slave: data is fetched during setup
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_ok;
  assign prdata  = prdata_reg;

  // two flop synchroniser for the async link pin
  // the first stage may go metastable, so only the second stage feeds the counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_meta_reg <= 1'b0;
      link_up_reg   <= 1'b0;
    end else begin
      link_meta_reg <= media_link_up;
      link_up_reg   <= link_meta_reg;
    end
  end

  // register writes; unmapped writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txcrc_reg  <= 16'h0000;
      pcsctl_reg <= `PCSCTL_RST;
      adv_reg    <= `ADV_RST;
    end else if (wr_go) begin
      if (sel_txcrc) begin
        txcrc_reg <= txcrc_next;
      end
      if (sel_pcsctl) begin
        pcsctl_reg <= pcsctl_next;
      end
      // the stored word only opens while forcing is on
      if (sel_adv && pcsctl_reg[`BIT_FORCEADV]) begin
        adv_reg <= adv_next;
      end
    end
  end

  // read capture in setup phase so prdata is a flop output
  // trade-off: reads show register state one cycle before the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_reg <= {16'h0000, rd_word};
    end
  end

  // both counters run only with link up, whatever the selector
  // holding at the top keeps a stuck error source from wrapping to a small count
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg[i] <= 8'h00;
      end else if (ev[i] && link_up_reg && cnt_reg[i] != `CNT_MAX) begin
        cnt_reg[i] <= cnt_reg[i] + 8'h01;
      end
    end
  end

  // media transmit controls, registered
  // registering costs a cycle but keeps decode glitches off the media serialiser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_word_tx <= 16'h0000;
      fefi_tx     <= 1'b0;
      hls_tx      <= 1'b0;
    end else begin
      adv_word_tx <= ctrl.force_adv ? adv_reg : auto_adv_word;
      fefi_tx     <= ctrl.force_fefi ? ctrl.fefi_val : fefi_auto;
      hls_tx      <= ctrl.force_hls;
    end
  end

  // per-frame egress actions, one cycle pulses after the start
  // the framer acts on these in the byte that follows the frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      egress_act <= '0;
    end else begin
      egress_act.drop_pre_byte  <= egress_sof & ctrl.preamble_fix & (preamble_len > `PRE_MAX);
      egress_act.drop_first_55  <= egress_sof & odd_start & ctrl.odd_inhibit;
      egress_act.delay_one_byte <= egress_sof & odd_start & ~ctrl.odd_inhibit;
    end
  end

  // checks on the logic above
  // all checks sleep while reset is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sel_view;
    (cnt_sel == `SEL_MAC) |-> (cnt_view == cnt_reg[1]);
  endproperty
  a_sel_view: assert property (p_sel_view) else $error("selector view wrong");

  property p_pre_drop;
    egress_sof && ctrl.preamble_fix && preamble_len == 5'h08 |=> !egress_act.drop_pre_byte;
  endproperty
  a_pre_drop: assert property (p_pre_drop) else $error("eight byte preamble trimmed");

  property p_sat;
    cnt_reg[0] == `CNT_MAX |=> cnt_reg[0] == `CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");

  property p_link_gate;
    !link_up_reg |=> $stable(cnt_reg[0]) && $stable(cnt_reg[1]);
  endproperty
  a_link_gate: assert property (p_link_gate) else $error("count with link down");

  property p_rf_read;
    setup_ph && sel_pcsctl |=> prdata[15:14] == $past(remote_fault_sent);
  endproperty
  a_rf_read: assert property (p_rf_read) else $error("remote fault readback");

  property p_pardet;
    wr_go && sel_pcsctl && pstrb[1] |=> ctrl.par_det_en == $past(pwdata[13]);
  endproperty
  a_pardet: assert property (p_pardet) else $error("parallel detect write");

  property p_cext_rst;
    $rose(presetn) |-> ctrl.carrier_ext_dis;
  endproperty
  a_cext_rst: assert property (@(posedge pclk) p_cext_rst) else $error("carrier ext reset");

  property p_force_adv;
    ctrl.force_adv ##1 ctrl.force_adv |-> adv_word_tx == $past(adv_reg);
  endproperty
  a_force_adv: assert property (p_force_adv) else $error("forced word not sent");

  property p_pol;
    wr_go && sel_pcsctl && pstrb[0] |=> ctrl.rx_pol_inv == $past(pwdata[6]) && ctrl.tx_pol_inv == $past(pwdata[5]);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity bits");

  property p_odd;
    egress_sof && odd_start |=> egress_act.drop_first_55 != egress_act.delay_one_byte;
  endproperty
  a_odd: assert property (p_odd) else $error("odd start action");

  property p_hls;
    ctrl.force_hls [*2] |-> hls_tx;
  endproperty
  a_hls: assert property (p_hls) else $error("hls not sent");

  property p_fefi_auto;
    !ctrl.force_fefi |=> fefi_tx == $past(fefi_auto);
  endproperty
  a_fefi_auto: assert property (p_fefi_auto) else $error("fefi not automatic");

  property p_fefi_val;
    ctrl.force_fefi |=> fefi_tx == $past(ctrl.fefi_val);
  endproperty
  a_fefi_val: assert property (p_fefi_val) else $error("fefi value ignored");

  property p_adv_lock;
    !ctrl.force_adv |=> $stable(adv_reg);
  endproperty
  a_adv_lock: assert property (p_adv_lock) else $error("adv word written unforced");

  property p_rsvd;
    setup_ph && sel_txcrc |=> prdata[12:8] == 5'h00 && prdata[31:16] == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  property p_sel_rsvd;
    setup_ph && sel_txcrc && cnt_sel[1] |=> prdata[7:0] == 8'h00;
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("reserved selector shows a count");

  property p_cnt_step;
    ev[1] && link_up_reg && cnt_reg[1] != `CNT_MAX |=> cnt_reg[1] == $past(cnt_reg[1]) + 8'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("mac count missed an error");

  property p_ctl_rsvd;
    setup_ph && sel_pcsctl |=> prdata[10:7] == 4'h0 && !prdata[3];
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits nonzero");

  property p_unmapped_rd;
    setup_ph && !addr_ok |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read nonzero");

  // covers for the main scenarios
  c_sat:   cover property (cnt_reg[1] == `CNT_MAX);
  c_trim:  cover property (egress_act.drop_pre_byte);
  c_force: cover property (wr_go && sel_adv && ctrl.force_adv);
  c_err:   cover property (pslverr);
  c_delay: cover property (egress_act.delay_one_byte);

endmodule

// ===== tb/pcs_far_side.sv
// far side model: media link, crc error sources, negotiation inputs and egress framer
`timescale 1ns/1ps
module pcs_far_side (
  input  wire logic        pclk,              // shared clock
  output logic             media_link_up,     // media link state
  output logic             media_tx_crc_err,  // media crc error pulse
  output logic             mac_tx_crc_err,    // mac crc error pulse
  output logic [1:0]       remote_fault_sent, // remote fault of last exchange
  output logic [15:0]      auto_adv_word,     // automatically built ability word
  output logic             fefi_auto,         // automatic far-end fault request
  output logic             egress_sof,        // frame start pulse
  output logic [4:0]       preamble_len,      // preamble length of frame
  output logic             odd_start          // odd byte start
);
  // quiet link and framer at time zero
  initial begin
    {media_link_up, media_tx_crc_err, mac_tx_crc_err, egress_sof} = 4'h0;
    {remote_fault_sent, auto_adv_word, fefi_auto} = 19'h0;
    {preamble_len, odd_start} = 6'h0;
  end
  // negotiation results, levels held until changed
  task automatic set_neg(input logic [1:0] rf, input logic [15:0] adv, input logic fe);
    @(posedge pclk);
    remote_fault_sent <= rf;
    auto_adv_word <= adv;
    fefi_auto <= fe;
  endtask
  // link pin is asynchronous in the real part, here moved on an edge
  task automatic set_link(input logic up);
    @(posedge pclk);
    media_link_up <= up;
  endtask
  // n back-to-back error pulses, one count each while link is up and below saturation
  task automatic crc(input logic med, input logic mac, input int n);
    repeat (n) begin
      @(posedge pclk);
      media_tx_crc_err <= med;
      mac_tx_crc_err <= mac;
    end
    @(posedge pclk);
    {media_tx_crc_err, mac_tx_crc_err} <= 2'h0;
  endtask
  // one frame start; qualifiers are inverted afterwards so stale values never look valid
  task automatic frame(input logic [4:0] len, input logic odd);
    @(posedge pclk);
    egress_sof <= 1'b1;
    preamble_len <= len;
    odd_start <= odd;
    @(posedge pclk);
    egress_sof <= 1'b0;
    preamble_len <= ~len;
    odd_start <= ~odd;
  endtask
endmodule

// ===== tb/serdes_pcs_ctrl_tx_crc_counter_tb.sv
// self-checking bench for the media pcs control and tx crc counter bank
`timescale 1ns/1ps
`include "serdes_pcs_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module serdes_pcs_ctrl_tx_crc_counter_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb master side
  logic [11:0] paddr = 12'h000;                              // byte address
  logic [31:0] pwdata = 32'h0, prdata, rd;                   // data and last read
  logic pready, pslverr, err, fefi_tx, hls_tx;               // slave answers
  logic media_link_up, media_tx_crc_err, mac_tx_crc_err, fefi_auto, egress_sof, odd_start;
  logic [1:0] remote_fault_sent;                             // from far side
  logic [4:0] preamble_len;                                  // from far side
  logic [15:0] auto_adv_word, adv_word_tx;                   // ability words
  serdes_pcs_pkg::pcs_ctrl_t ctrl;                           // control levels
  serdes_pcs_pkg::egress_act_t egress_act;                   // egress pulses
  int n_errors = 0, tests_run = 0;                           // tallies
  localparam logic [11:0] A_CNT = 12'h058, A_CTL = 12'h05c, A_ADV = 12'h064; // 4 * index
  always #25 pclk = ~pclk;                                   // 20 mhz
  serdes_pcs_ctrl_tx_crc_counter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .media_link_up(media_link_up), .media_tx_crc_err(media_tx_crc_err),
    .mac_tx_crc_err(mac_tx_crc_err), .remote_fault_sent(remote_fault_sent), .auto_adv_word(auto_adv_word),
    .fefi_auto(fefi_auto), .egress_sof(egress_sof), .preamble_len(preamble_len), .odd_start(odd_start),
    .ctrl(ctrl), .egress_act(egress_act), .adv_word_tx(adv_word_tx), .fefi_tx(fefi_tx), .hls_tx(hls_tx));
  pcs_far_side far (.pclk(pclk), .media_link_up(media_link_up), .media_tx_crc_err(media_tx_crc_err),
    .mac_tx_crc_err(mac_tx_crc_err), .remote_fault_sent(remote_fault_sent), .auto_adv_word(auto_adv_word),
    .fefi_auto(fefi_auto), .egress_sof(egress_sof), .preamble_len(preamble_len), .odd_start(odd_start));
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // registered outputs trail their cause by a cycle
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // egress pulse is looked at in the one cycle it stands
  task automatic frame_chk(input logic [4:0] len, input logic odd, input logic [2:0] exp);
    far.frame(len, odd);
    #1;
    `CHK(egress_act, exp)
  endtask
  // closing point for normal end and watchdog
  task automatic give_verdict;
    $display("checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, well above the roughly 400 cycles of the sequence
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    far.set_neg(2'h2, 16'h01a0, 1'b1);
    apb(0, A_CNT, 0); `CHK(rd[15:0], 16'h0000)
    `CHK({err, pready}, 2'h1)
    apb(0, A_CTL, 0); `CHK(rd[15:0], 16'h9010)
    `CHK(ctrl, 10'h088)
    `CHK(adv_word_tx, 16'h01a0)
    `CHK({fefi_tx, hls_tx}, 2'h2)
    apb(1, A_ADV, 32'h1234); apb(0, A_ADV, 0); `CHK(rd[15:0], 16'h0000)
    apb(1, A_CTL, 32'h0800);
    apb(1, A_ADV, 32'h0020);
    apb(0, A_ADV, 0); `CHK(rd[15:0], 16'h0020)
    apb(1, A_CTL, 32'hffff); apb(0, A_CTL, 0); `CHK(rd[15:0], 16'hb877)
    settle(); `CHK(ctrl, 10'h1ff)
    `CHK({adv_word_tx, fefi_tx, hls_tx}, 18'h00083)
    apb(1, A_CTL, 32'h0002); settle(); `CHK(ctrl, 10'h002)
    `CHK({adv_word_tx, fefi_tx, hls_tx}, 18'h00680)
    frame_chk(5'h05, 1'b1, 3'h1);
    apb(1, A_CNT, 32'h2000);
    frame_chk(5'h09, 1'b0, 3'h4);
    frame_chk(5'h08, 1'b0, 3'h0);
    apb(1, A_CTL, 32'h1010);
    frame_chk(5'h08, 1'b1, 3'h2);
    far.crc(1, 1, 3); apb(0, A_CNT, 0); `CHK(rd[15:0], 16'h2000)
    far.set_link(1'b1);
    repeat (4) @(posedge pclk);
    far.crc(1, 0, 5); far.crc(0, 1, 2);
    apb(0, A_CNT, 0); `CHK(rd[15:0], 16'h2005)
    apb(1, A_CNT, 32'h5fff); apb(0, A_CNT, 0); `CHK(rd[15:0], 16'h4002)
    apb(1, A_CNT, 32'hc000); apb(0, A_CNT, 0); `CHK(rd[15:0], 16'hc000)
    apb(1, A_CNT, 32'h0000); far.crc(1, 0, 300);
    apb(0, A_CNT, 0); `CHK(rd[15:0], 16'h00ff)
    apb(1, 12'h060, 32'hffff); `CHK(err, 1'b1)
    apb(0, 12'h060, 0); `CHK({err, rd}, 33'h100000000)
    give_verdict();
  end
endmodule
